// >>> design/msa_arm.sv
/*
  measurement start arming qualifier: chooses an arming source, optional
  programmable start delay, armed window and start/stop qualification.
  assumes trigger inputs are already comparator outputs synchronous to ref_clk
  and that the measurement core reports end of measurement with meas_done.
*/
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "msa_consts.svh"
module msa_arm (
    input wire logic ref_clk,              // 200 MHz timebase
    input wire logic rst_n,                // sync reset, active low
    input wire msa_pkg::msa_bus_type bus,  // register port requests
    output logic [31:0] rdata,             // read data, cycle after rd
    input wire msa_pkg::msa_trig_type trig,// comparator levels A, B, E
    input wire logic meas_done,            // core finished a measurement
    output logic meas_start,               // one-cycle start pulse
    output logic meas_stop,                // one-cycle stop pulse
    output logic measuring,                // measurement in progress
    output logic armed                     // qualifier is set
);
    import msa_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl_q, ctrl_d;
    logic [27:0] dly_q, dly_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] starts_q, starts_d;

    // register writes; delay is clamped into the settable range
    always_comb begin
        ctrl_d = ctrl_q;
        dly_d = dly_q;
        if (bus.wr && bus.addr == `MSA_OFS_CTRL) begin
            ctrl_d = bus.wdata;
        end
        if (bus.wr && bus.addr == `MSA_OFS_DELAY) begin
            if (bus.wdata[27:0] == 28'h000_0000) begin
                dly_d = 28'h000_0000;
            end else if (bus.wdata[27:0] < `MSA_DELAY_MIN_STEPS) begin
                dly_d = `MSA_DELAY_MIN_STEPS;
            end else if (bus.wdata[27:0] > `MSA_DELAY_MAX_STEPS) begin
                dly_d = `MSA_DELAY_MAX_STEPS;
            end else begin
                dly_d = bus.wdata[27:0];
            end
        end
    end

    logic arm_en, arm_neg, ti_mode;
    msa_src_type src;
    assign arm_en = ctrl_q[`MSA_CTRL_ARM_EN];
    assign arm_neg = ctrl_q[`MSA_CTRL_ARM_NEG];
    assign ti_mode = ctrl_q[`MSA_CTRL_TI_MODE];
    assign src = msa_src_type'(ctrl_q[`MSA_CTRL_SRC_HI:`MSA_CTRL_SRC_LO]);

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    logic edge_a, edge_b, edge_e, arm_a, arm_b;
    logic b_path;

    // channel B self-arm hears channel A internally, no external tap
    assign b_path = (src == MSA_SRC_B) ? trig.chan_a : trig.chan_b;

    // measuring triggers: channel A start slope, channel B stop slope
    msa_edge u_start_a (.ref_clk(ref_clk), .rst_n(rst_n), .sig(trig.chan_a),
        .neg(1'b0), .edge_p(edge_a));
    msa_edge u_stop_b (.ref_clk(ref_clk), .rst_n(rst_n), .sig(trig.chan_b),
        .neg(1'b0), .edge_p(edge_b));
    // arming edges take their own polarity
    msa_edge u_arm_e (.ref_clk(ref_clk), .rst_n(rst_n), .sig(trig.chan_e),
        .neg(arm_neg), .edge_p(edge_e));
    msa_edge u_arm_a (.ref_clk(ref_clk), .rst_n(rst_n), .sig(trig.chan_a),
        .neg(arm_neg), .edge_p(arm_a));
    msa_edge u_arm_b (.ref_clk(ref_clk), .rst_n(rst_n), .sig(b_path),
        .neg(arm_neg), .edge_p(arm_b));

    logic arm_edge;
    always_comb begin
        unique case (src)
            MSA_SRC_A: arm_edge = arm_a;
            MSA_SRC_B: arm_edge = arm_b;
            default: arm_edge = edge_e;
        endcase
    end

    logic stop_edge;
    assign stop_edge = ti_mode ? edge_b : edge_a;

    // ----------------------------------------------------------------
    // arming sequencer
    // ----------------------------------------------------------------
    msa_state_type st_q, st_d;
    logic [27:0] step_q, step_d;   // 10 ns steps elapsed
    logic [3:0] sub_q, sub_d;      // clocks within a step / setup
    logic start_p, stop_p;

    always_comb begin
        st_d = st_q;
        step_d = step_q;
        sub_d = sub_q;
        start_p = 1'b0;
        stop_p = 1'b0;
        unique case (st_q)
            MSA_IDLE: begin
                // free run: start on every channel A trigger that arrives while idle
                if (!arm_en && edge_a) begin
                    start_p = 1'b1;
                    st_d = MSA_RUN;
                end else if (arm_en) begin
                    st_d = MSA_WAIT_EDGE;
                end
            end
            MSA_WAIT_EDGE: begin
                step_d = 28'h000_0000;
                sub_d = 4'h0;
                if (!arm_en) begin
                    st_d = MSA_IDLE;
                end else if (arm_edge) begin
                    st_d = MSA_DELAY;
                end
            end
            MSA_DELAY: begin
                if (dly_q == 28'h000_0000) begin
                    // setup time before the qualifier takes effect
                    sub_d = sub_q + 4'h1;
                    if (sub_q + 4'h1 >= 4'(`MSA_SETUP_CYC)) begin
                        st_d = MSA_ARMED;
                    end
                end else begin
                    if (sub_q + 4'h1 >= 4'(`MSA_STEP_CYC)) begin
                        sub_d = 4'h0;
                        step_d = step_q + 28'h000_0001;
                    end else begin
                        sub_d = sub_q + 4'h1;
                    end
                    // window opens early so a trigger just before expiry is taken
                    if ((step_q + 28'(`MSA_EARLY_NS / `MSA_DELAY_STEP_NS)) >= dly_q) begin
                        st_d = MSA_ARMED;
                    end
                end
                if (!arm_en) begin
                    st_d = MSA_IDLE;
                end
            end
            MSA_ARMED: begin
                // first trigger after the armed condition starts the run
                if (edge_a) begin
                    start_p = 1'b1;
                    st_d = MSA_RUN;
                end else if (!arm_en) begin
                    st_d = MSA_IDLE;
                end
            end
            MSA_RUN: begin
                if (ti_mode && stop_edge) begin
                    stop_p = 1'b1;
                    st_d = arm_en ? MSA_WAIT_EDGE : MSA_IDLE;
                end else if (!ti_mode && meas_done) begin
                    stop_p = 1'b1;
                    st_d = arm_en ? MSA_WAIT_EDGE : MSA_IDLE;
                end
            end
            default: st_d = MSA_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // status and read port
    // ----------------------------------------------------------------
    always_comb begin
        starts_d = start_p ? starts_q + 32'h0000_0001 : starts_q;
        rdata_d = 32'h0000_0000;
        if (bus.rd) begin
            unique case (bus.addr)
                `MSA_OFS_CTRL: rdata_d = ctrl_q;
                `MSA_OFS_DELAY: rdata_d = {4'h0, dly_q};
                `MSA_OFS_STATUS: rdata_d = {27'h0, (st_q == MSA_RUN),
                    (st_q == MSA_ARMED), st_q};
                `MSA_OFS_COUNT: rdata_d = starts_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // register file; reset leaves arming off and the delay undelayed
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q <= `MSA_CTRL_RESET;
            dly_q <= 28'h000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            dly_q <= dly_d;
        end
    end

    // sequencer; an arming edge in the single idle-to-wait cycle is missed
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= MSA_IDLE;
            step_q <= 28'h000_0000;
            sub_q <= 4'h0;
        end else begin
            st_q <= st_d;
            step_q <= step_d;
            sub_q <= sub_d;
        end
    end

    // read data and start count, kept apart so status reads never stall arming
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
            starts_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
            starts_q <= starts_d;
        end
    end

    assign rdata = rdata_q;
    assign meas_start = start_p;
    assign meas_stop = stop_p;
    assign measuring = (st_q == MSA_RUN);
    assign armed = (st_q == MSA_ARMED);
endmodule // msa_arm

// >>> design/msa_edge.sv
/*
  edge detector with selectable polarity, one per input trigger path.
  assumes the input is already synchronous to ref_clk.
*/
`timescale 1ns/1ps
module msa_edge (
    input wire logic ref_clk,   // timebase
    input wire logic rst_n,     // sync reset, active low
    input wire logic sig,       // level in
    input wire logic neg,       // 1 selects falling edge
    output logic edge_p         // one-cycle edge pulse
);
    logic prev_q;
    logic prev_d;

    // history of the level
    always_comb begin
        prev_d = sig;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    // polarity applied after the history so it can change without a spurious edge
    assign edge_p = neg ? (prev_q & ~sig) : (~prev_q & sig);
endmodule // msa_edge

// >>> inc/msa_consts.svh
// Notes on behaviour
// - channel B self-arm takes channel A's signal
// - start delay 20ns to 2s, 10ns steps
// - undelayed arming armed about 5 ns after edge; here armed 2 clocks (10 ns) after it
// - delayed arming accepts start 60 ns early
// - arming edge polarity selectable, independent of slope
// - zero delay is undelayed; source selectable incl E
// - same-channel interval: start A, stop B settings
// - stop on first qualifying stop after start
// - free run only aligns to first event; here every channel A trigger while idle starts a run
// - arming enabled: each start needs arming edge
// - start synced to first trigger after armed
/*
  constants for the measurement start arming block: register offsets, field
  positions, reset values and timing counts. assumes a 200 MHz ref_clk.
*/
`ifndef MSA_CONSTS_SVH
`define MSA_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MSA_OFS_CTRL 4'h0
`define MSA_OFS_DELAY 4'h1
`define MSA_OFS_STATUS 4'h2
`define MSA_OFS_COUNT 4'h3

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define MSA_CTRL_ARM_EN 0
`define MSA_CTRL_ARM_NEG 1
`define MSA_CTRL_SRC_LO 2
`define MSA_CTRL_SRC_HI 3
`define MSA_CTRL_TI_MODE 4
`define MSA_CTRL_RESET 32'h0000_0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MSA_CLK_PERIOD_PS 5000
`define MSA_DELAY_STEP_NS 10
`define MSA_DELAY_MIN_STEPS 28'h000_0002
`define MSA_DELAY_MAX_STEPS 28'hbeb_c200
`define MSA_SETUP_NS 5
`define MSA_EARLY_NS 60
`define MSA_SETUP_CYC ((`MSA_SETUP_NS * 1000 + `MSA_CLK_PERIOD_PS - 1) / `MSA_CLK_PERIOD_PS)
`define MSA_EARLY_CYC ((`MSA_EARLY_NS * 1000) / `MSA_CLK_PERIOD_PS)
`define MSA_STEP_CYC ((`MSA_DELAY_STEP_NS * 1000) / `MSA_CLK_PERIOD_PS)

`endif

// >>> inc/msa_pkg.sv
/*
  types for the measurement start arming block.
  assumes msa_consts.svh is on the include path.
*/
package msa_pkg;

    typedef enum logic [1:0] {
        MSA_SRC_E = 2'b00,
        MSA_SRC_A = 2'b01,
        MSA_SRC_B = 2'b10
    } msa_src_type;

    typedef enum logic [2:0] {
        MSA_IDLE = 3'b000,
        MSA_WAIT_EDGE = 3'b001,
        MSA_DELAY = 3'b010,
        MSA_ARMED = 3'b011,
        MSA_RUN = 3'b100
    } msa_state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } msa_bus_type;

    typedef struct packed {
        logic chan_a;
        logic chan_b;
        logic chan_e;
    } msa_trig_type;

endpackage

// >>> verification/msa_arm_properties.sv
/* checker for the arming qualifier, seeing only the ports of msa_arm.
   assumes ctrl and delay change only through writes on bus. */
`timescale 1ns/1ps
module msa_arm_props (
    input wire logic ref_clk, // timebase
    input wire logic rst_n, // sync reset, active low
    input wire msa_pkg::msa_bus_type bus, // register port
    input wire logic [31:0] rdata, // read data
    input wire msa_pkg::msa_trig_type trig, // comparator levels
    input wire logic meas_done, // core finished
    input wire logic meas_start, // start pulse
    input wire logic meas_stop, // stop pulse
    input wire logic measuring, // in progress
    input wire logic armed // qualifier set
);
    import msa_pkg::*;
    logic [4:0] ctl_q, ctl_d;
    logic [27:0] dly_q, dly_d;
    logic e_go;
    // ------
    // shadow of the mode registers, so rules can depend on the mode
    // ------
    always_comb begin
        ctl_d = ctl_q;
        dly_d = dly_q;
        if (bus.wr && bus.addr == 4'h0) ctl_d = bus.wdata[4:0];
        if (bus.wr && bus.addr == 4'h1) dly_d = bus.wdata[27:0];
    end
    always_ff @(posedge ref_clk) begin
        ctl_q <= rst_n ? ctl_d : 5'h00;
        dly_q <= rst_n ? dly_d : 28'h0000000;
    end
    // waiting on a rising edge of the rear input
    assign e_go = ctl_q[0] && ctl_q[3:1] == 3'b000 && !measuring && !armed;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_start_needs_trig: assert property (meas_start |-> (trig.chan_a || $past(trig.chan_a)))
        else $error("start without a channel A trigger");
    a_start_clears_arm: assert property (meas_start |=> measuring && !armed)
        else $error("qualifier not cleared at start");
    a_start_when_armed: assert property ((ctl_q[0] && meas_start) |-> armed)
        else $error("start while arming enabled but not armed");
    a_armed_needs_en: assert property (armed |-> (ctl_q[0] || $past(ctl_q[0])))
        else $error("armed with arming disabled");
    a_no_restart_run: assert property (measuring |-> !meas_start)
        else $error("second start during a measurement");
    a_stop_ends_meas: assert property (meas_stop |-> measuring ##1 !measuring)
        else $error("stop not ending a measurement");
    a_stop_cause_b: assert property (meas_stop |-> (meas_done || trig.chan_b || $past(trig.chan_b)))
        else $error("stop without its cause");
    a_undelayed_setup: assert property ((e_go && dly_q == 28'h0 && $rose(trig.chan_e))
        |-> ##[1:4] armed)
        else $error("undelayed arming too slow");
    a_delay_holdoff: assert property ((e_go && dly_q >= 28'h000000c && $rose(trig.chan_e))
        |=> !armed [*8])
        else $error("delayed arming armed too early");
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
        else $error("read data outside its cycle");
    c_start: cover property (meas_start);
    c_stop: cover property (meas_stop);
    c_armed: cover property ($rose(armed));
endmodule // msa_arm_props
bind msa_arm msa_arm_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .trig(trig), .meas_done(meas_done), .meas_start(meas_start), .meas_stop(meas_stop),
    .measuring(measuring), .armed(armed));

// >>> verification/msa_src.sv
/* far side: sync source on E and a pulse burst on A and B.
   assumes go is a one-cycle request given after a rising edge. */
`timescale 1ns/1ps
module msa_src #(parameter int HALF = 3) (
    input wire logic ref_clk, // timebase
    input wire logic go, // one sync plus burst
    input wire logic [7:0] lead, // cycles from sync rise to first pulse
    input wire logic [2:0] n_pulses, // pulses in the burst
    output msa_pkg::msa_trig_type trig // comparator levels
);
    import msa_pkg::*;
    int i;
    // sync is two cycles wide so either of its slopes can arm
    initial begin
        trig = '0;
        forever begin
            @(posedge ref_clk);
            if (go) begin
                trig.chan_e <= 1'b1;
                repeat (2) @(posedge ref_clk);
                trig.chan_e <= 1'b0;
                repeat (lead - 8'd2) @(posedge ref_clk);
                for (i = 0; i < n_pulses; i++) begin
                    trig.chan_a <= 1'b1;
                    trig.chan_b <= 1'b1;
                    repeat (HALF) @(posedge ref_clk);
                    trig.chan_a <= 1'b0;
                    trig.chan_b <= 1'b0;
                    repeat (HALF) @(posedge ref_clk);
                end
            end
        end
    end
endmodule // msa_src

// >>> verification/test_measurement_start_arming.sv
/* bench: register port, free run, armed, self-armed, delayed and interval runs.
   assumes msa_src drives the triggers; a stand-in core ends plain runs. */
`timescale 1ns/1ps
`include "msa_consts.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module test_measurement_start_arming;
    import msa_pkg::*;
    localparam int PER = 6;
    logic ref_clk, rst_n, meas_done, go, ti_on, arm_q;
    logic meas_start, meas_stop, measuring, armed;
    msa_bus_type bus;
    msa_trig_type trig;
    logic [31:0] rdata, d;
    logic [7:0] lead;
    logic [2:0] n_pulses, n;
    integer n_errors = 0, check_count = 0, cyc = 0, n_st = 0, exp_starts = 0;
    integer t_go, t_arm, t_start, t_stop, k, seed = 32'h83a2621a;
    int exp_q[$];
    msa_arm dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .trig(trig),
        .meas_done(meas_done), .meas_start(meas_start), .meas_stop(meas_stop),
        .measuring(measuring), .armed(armed));
    msa_src #(.HALF(PER / 2)) u_src (.ref_clk(ref_clk), .go(go), .lead(lead),
        .n_pulses(n_pulses), .trig(trig));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // ------
    // monitor, stand-in core and hang guard
    // ------
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        arm_q <= armed;
        meas_done <= measuring && !ti_on && !meas_done;
        if (meas_start) n_st <= n_st + 1;
        if (meas_start) t_start <= cyc;
        if (meas_stop) t_stop <= cyc;
        if (armed && !arm_q) t_arm <= cyc;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge ref_clk);
        bus <= '0;
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge ref_clk);
        bus <= '0;
        #1 v = rdata;
    endtask
    // one frame from the far side, waited out whole
    task automatic burst(input logic [7:0] l, input logic [2:0] np);
        @(posedge ref_clk);
        lead <= l;
        n_pulses <= np;
        go <= 1'b1;
        t_go = cyc;
        n_st = 0;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (l + np * PER + 12) @(posedge ref_clk);
    endtask
    // model: starts per frame, start total and resting state
    task automatic settle(input integer exp_n, input logic [31:0] st);
        exp_q.push_back(exp_n);
        exp_starts = exp_starts + exp_q[$];
        `CHK(n_st, exp_q[$])
        bus_rd(4'h3, d);
        `CHK(d, exp_starts[31:0])
        bus_rd(4'h2, d);
        `CHK(d, st)
        $display("test done at %0t, starts %0d", $time, n_st);
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        bus = '0;
        go = 1'b0;
        ti_on = 1'b0;
        meas_done = 1'b0;
        arm_q = 1'b0;
        lead = 8'h08;
        n_pulses = 3'h1;
        rst_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (k = 0; k < 5; k++) begin
            bus_rd(k == 4 ? 4'h9 : k[3:0], d);
            `CHK(d, 32'h0)
        end
        bus_wr(4'h9, 32'hffffffff);
        bus_rd(4'h0, d);
        `CHK(d, 32'h0)
        bus_wr(4'h1, 32'h1);
        bus_rd(4'h1, d);
        `CHK(d, 32'h2)
        bus_wr(4'h1, 32'h0fff_ffff);
        bus_rd(4'h1, d);
        `CHK(d, 32'h0beb_c200)
        bus_wr(4'h1, 32'h14);
        bus_rd(4'h1, d);
        `CHK(d, 32'h14)
        bus_wr(4'h1, 32'h0);
        $display("register test done at %0t", $time);
        // free run: the single pulse of a frame starts one run
        burst(8'h08, 3'h1);
        settle(1, 32'h0);
        for (k = 0; k < 2; k++) begin
            bus_wr(4'h0, k == 0 ? 32'h1 : 32'h3);
            burst(8'(8 + ($random(seed) & 7)), 3'(2 + ($random(seed) & 3)));
            settle(1, {29'h0, MSA_WAIT_EDGE});
        end
        // self-arming: pulses alternately arm and start
        for (k = 1; k < 3; k++) begin
            bus_wr(4'h0, 32'((k << 2) | 1));
            n = 3'(2 + 2 * ($random(seed) & 1));
            burst(8'h08, n);
            settle(n / 2, {29'h0, MSA_WAIT_EDGE});
        end
        bus_wr(4'h0, 32'h1);
        bus_wr(4'h1, 32'h14);
        for (k = 38; k < 60; k += 12) begin
            burst(8'(k), 3'h2);
            `CHK((t_arm - t_go - 3 - 14 * `MSA_STEP_CYC) inside {[-3:3]}, 1'b1)
            settle(1, {29'h0, MSA_WAIT_EDGE});
        end
        bus_wr(4'h1, 32'h0);
        bus_wr(4'h0, 32'h11);
        ti_on <= 1'b1;
        burst(8'h0a, 3'h3);
        `CHK(t_stop - t_start, PER)
        settle(1, {29'h0, MSA_WAIT_EDGE});
        print_verdict();
    end
endmodule // test_measurement_start_arming
